// ===== design/dtrig_map.svh
/*
 * Register offsets, field positions and reset values of the debug trigger
 * block. Assumes inclusion by the package and by the design module.
 */
`ifndef DTRIG_MAP_SVH
`define DTRIG_MAP_SVH

// Byte offsets on the register bus.
`define DTRIG_OFF_TRIG_CFG   12'h000
`define DTRIG_OFF_STATUS     12'h004
`define DTRIG_OFF_DEBUG_CTL  12'h008

// Trigger setup fields.
`define DTRIG_CFG_QUAL_BIT   7
`define DTRIG_CFG_BEGIN_BIT  6
`define DTRIG_CFG_WMASK      8'hCF

// Debug control fields.
`define DTRIG_CTL_EN_BIT     7
`define DTRIG_CTL_ARM_BIT    6
`define DTRIG_CTL_BRK_BIT    4

// Status fields.
`define DTRIG_ST_AF_BIT      7
`define DTRIG_ST_BF_BIT      6
`define DTRIG_ST_RUN_ARMED_FLAG_BIT    5

// Trigger modes.
`define DTRIG_MODE_A_ONLY    4'h0
`define DTRIG_MODE_A_OR_B    4'h1
`define DTRIG_MODE_A_THEN_B  4'h2
`define DTRIG_MODE_EV_B      4'h3
`define DTRIG_MODE_A_EV_B    4'h4
`define DTRIG_MODE_A_AND_BD  4'h5
`define DTRIG_MODE_A_NBD     4'h6
`define DTRIG_MODE_INSIDE    4'h7
`define DTRIG_MODE_OUTSIDE   4'h8

// Reset values and FIFO depth.
`define DTRIG_RST_BYTE       8'h00
`define DTRIG_FIFO_DEPTH     8

`endif

// ===== design/dtrig_pkg.sv
/*
 * Types shared by the debug trigger block. Assumes the constants header.
 */
`include "dtrig_map.svh"
package dtrig_pkg;

  // Per-access comparator inputs.
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        exec_a;
    logic        exec_b;
  } dtrig_acc_s;

  typedef enum logic [1:0] {DTRIG_IDLE, DTRIG_RUN} dtrig_run_e;

endpackage : dtrig_pkg

// ===== design/dtrig_core.sv
/*
 * Trigger selection, run control and status of the debug trace unit, as an
 * APB slave. Assumes comparator values and bus-access samples arrive
 * synchronous to ref_clk, and a FIFO outside accepts store strobes.
 */
`timescale 1ns/1ps
`include "dtrig_map.svh"
module dtrig_core
  import dtrig_pkg::*;
#(
  parameter int DEPTH = `DTRIG_FIFO_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        secure,
  input  wire logic [15:0] cmp_a,
  input  wire logic [15:0] cmp_b,
  input  wire dtrig_acc_s  acc,
  output      logic        fifo_store,
  output      logic        brk_req,
  output      logic        trig_tag
);

  // The valid count is four bits wide, so the depth must fit in it.
  if (DEPTH < 1 || DEPTH > 15) begin : g_depth_chk
    $error("DEPTH must lie between 1 and 15");
  end

  // ******************************************************************
  // Registers and decode
  // ******************************************************************
  logic [7:0] trigger_config_reg;
  logic [7:0] debug_control_reg;
  logic       match_a_flag;
  logic       match_b_flag;
  logic [3:0] valid_word_count;
  logic       a_seen;
  dtrig_run_e run_state;

  logic access;
  logic wr_cfg;
  logic wr_ctl;
  logic hit;
  logic run_end;
  logic run_start;
  logic trig;
  logic store;
  logic event_only;
  logic begin_trace;
  logic full;
  logic [7:0] next_ctl;
  logic [7:0] status_byte;

  assign access = psel && penable;
  assign wr_cfg = access && pwrite && paddr == `DTRIG_OFF_TRIG_CFG;
  assign wr_ctl = access && pwrite && paddr == `DTRIG_OFF_DEBUG_CTL;
  assign hit    = paddr == `DTRIG_OFF_TRIG_CFG ||
                  paddr == `DTRIG_OFF_STATUS ||
                  paddr == `DTRIG_OFF_DEBUG_CTL;

  // ******************************************************************
  // Trigger decode
  // ******************************************************************
  logic a_raw;
  logic b_raw;
  logic a_m;
  logic b_m;
  logic [3:0] mode;

  assign mode  = trigger_config_reg[3:0];
  // Full modes use the data byte for B; others the address.
  assign a_raw = acc.valid && acc.addr == cmp_a;
  assign b_raw = acc.valid && ((mode == `DTRIG_MODE_A_AND_BD ||
                 mode == `DTRIG_MODE_A_NBD) ?
                 acc.data == cmp_b[7:0] : acc.addr == cmp_b);
  // Tag type waits for the opcode tracking to report execution.
  assign a_m = trigger_config_reg[`DTRIG_CFG_QUAL_BIT] ?
               (a_raw && acc.exec_a) : a_raw;
  assign b_m = trigger_config_reg[`DTRIG_CFG_QUAL_BIT] ?
               (b_raw && acc.exec_b) : b_raw;

  assign event_only  = mode == `DTRIG_MODE_EV_B ||
                       mode == `DTRIG_MODE_A_EV_B;
  assign begin_trace = event_only ||
                       trigger_config_reg[`DTRIG_CFG_BEGIN_BIT];
  assign full = valid_word_count == 4'(DEPTH);

  // Mode decode of the trigger event.
  always_comb begin
    trig = 1'b0;
    unique case (mode)
      `DTRIG_MODE_A_ONLY:   trig = a_m;
      `DTRIG_MODE_A_OR_B:   trig = a_m || b_m;
      `DTRIG_MODE_A_THEN_B: trig = a_seen && b_m;
      `DTRIG_MODE_EV_B:     trig = b_m;
      `DTRIG_MODE_A_EV_B:   trig = a_seen && b_m;
      `DTRIG_MODE_A_AND_BD: trig = a_m && b_m;
      `DTRIG_MODE_A_NBD:    trig = a_m && !b_m;
      `DTRIG_MODE_INSIDE:   trig = acc.valid && acc.addr >= cmp_a &&
                                   acc.addr <= cmp_b;
      `DTRIG_MODE_OUTSIDE:  trig = acc.valid && (acc.addr < cmp_a ||
                                   acc.addr > cmp_b);
      default:              trig = 1'b0;
    endcase
  end

  // Storage: event-only stores per event; begin after trigger; end every valid access.
  logic started;
  assign store = run_state == DTRIG_RUN && !full &&
                 (event_only ? trig :
                  begin_trace ? (started || trig) : acc.valid);
  // Run ends when full in begin trace, or trigger in end trace.
  assign run_end = run_state == DTRIG_RUN &&
                   (begin_trace ? (full || (store &&
                    valid_word_count == 4'(DEPTH - 1))) : trig);
  // Start comes from the write itself, so no loop runs through next_ctl.
  assign run_start = wr_ctl && pwdata[`DTRIG_CTL_ARM_BIT] &&
                     pwdata[`DTRIG_CTL_EN_BIT] &&
                     (debug_control_reg[`DTRIG_CTL_EN_BIT] || !secure);

  // ******************************************************************
  // Register writes
  // ******************************************************************
  // Trigger setup accepts writes only while disarmed; bits 4 and 5 fixed.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trigger_config_reg <= `DTRIG_RST_BYTE;
    end else if (wr_cfg && !debug_control_reg[`DTRIG_CTL_ARM_BIT]) begin
      trigger_config_reg <= pwdata[7:0] & `DTRIG_CFG_WMASK;
    end
  end

  // Enable is refused while secure; arm cleared when the run ends.
  always_comb begin
    next_ctl = debug_control_reg;
    if (wr_ctl) begin
      next_ctl = pwdata[7:0];
      if (secure && !debug_control_reg[`DTRIG_CTL_EN_BIT]) begin
        next_ctl[`DTRIG_CTL_EN_BIT] = 1'b0;
      end
    end
    if (!next_ctl[`DTRIG_CTL_EN_BIT]) begin
      next_ctl[`DTRIG_CTL_ARM_BIT] = 1'b0;
    end
    if (run_end && !run_start) begin
      next_ctl[`DTRIG_CTL_ARM_BIT] = 1'b0;
    end
  end

  // Control register update.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_control_reg <= `DTRIG_RST_BYTE;
    end else begin
      debug_control_reg <= next_ctl;
    end
  end

  // ******************************************************************
  // Run state, flags and count
  // ******************************************************************
  // Run tracks the arm bit; a fresh arm write restarts it.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_state <= DTRIG_IDLE;
    end else if (next_ctl[`DTRIG_CTL_ARM_BIT]) begin
      run_state <= DTRIG_RUN;
    end else begin
      run_state <= DTRIG_IDLE;
    end
  end

  // Sequence memory for A-then-B modes and begin-trace start.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      a_seen  <= 1'b0;
      started <= 1'b0;
    end else if (run_start) begin
      a_seen  <= 1'b0;
      started <= 1'b0;
    end else if (run_state == DTRIG_RUN) begin
      a_seen  <= a_seen || a_m;
      started <= started || trig;
    end
  end

  // Match flags: clear at run start, set on matches while running.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
    end else if (run_start) begin
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
    end else if (run_state == DTRIG_RUN) begin
      match_a_flag <= match_a_flag || a_m;
      match_b_flag <= match_b_flag || b_m;
    end
  end

  // Count saturates at depth; never decremented by readout.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_word_count <= 4'h0;
    end else if (run_start) begin
      valid_word_count <= 4'h0;
    end else if (store) begin
      valid_word_count <= valid_word_count + 4'h1;
    end
  end

  // FIFO strobe and break request.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_store <= 1'b0;
      brk_req    <= 1'b0;
      trig_tag   <= 1'b0;
    end else begin
      fifo_store <= store && !run_start;
      brk_req    <= debug_control_reg[`DTRIG_CTL_BRK_BIT] && run_end &&
                    !run_start;
      trig_tag   <= trigger_config_reg[`DTRIG_CFG_QUAL_BIT];
    end
  end

  // ******************************************************************
  // APB read and response
  // ******************************************************************
  assign status_byte = {match_a_flag, match_b_flag,
                        debug_control_reg[`DTRIG_CTL_EN_BIT] &&
                        debug_control_reg[`DTRIG_CTL_ARM_BIT],
                        1'b0, valid_word_count};

  // No wait state: pready is high in the first access-phase cycle.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `DTRIG_OFF_TRIG_CFG:  prdata <= {24'h00_0000,
                                           trigger_config_reg};
          `DTRIG_OFF_STATUS:    prdata <= {24'h00_0000, status_byte};
          `DTRIG_OFF_DEBUG_CTL: prdata <= {24'h00_0000,
                                           debug_control_reg};
          default:              prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Status writes are decoded nowhere, so they have no effect.

  // ******************************************************************
  // Assertions
  // ******************************************************************
  property p_cfg_locked;
    @(posedge ref_clk) disable iff (!rst_b)
    debug_control_reg[`DTRIG_CTL_ARM_BIT] && !wr_ctl |=>
      $stable(trigger_config_reg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked)
    else $error("trigger setup changed while armed");

  property p_rsv_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    trigger_config_reg[5:4] == 2'b00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved setup bits set");

  property p_no_trig;
    @(posedge ref_clk) disable iff (!rst_b)
    mode > `DTRIG_MODE_OUTSIDE |-> !trig;
  endproperty
  a_no_trig: assert property (p_no_trig)
    else $error("trigger in a no-trigger mode");

  property p_af_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    run_start |=> !match_a_flag && !match_b_flag &&
                  valid_word_count == 4'h0;
  endproperty
  a_af_clear: assert property (p_af_clear)
    else $error("flags not cleared at run start");

  property p_bf_set;
    @(posedge ref_clk) disable iff (!rst_b)
    run_state == DTRIG_RUN && b_m && !run_start |=> match_b_flag;
  endproperty
  a_bf_set: assert property (p_bf_set)
    else $error("match B flag not set");

  property p_end_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    run_end && !run_start |=> !debug_control_reg[`DTRIG_CTL_ARM_BIT];
  endproperty
  a_end_clear: assert property (p_end_clear)
    else $error("arm not cleared at run end");

  property p_cnt_max;
    @(posedge ref_clk) disable iff (!rst_b)
    valid_word_count <= 4'(DEPTH);
  endproperty
  a_cnt_max: assert property (p_cnt_max)
    else $error("valid count above depth");

  property p_secure;
    @(posedge ref_clk) disable iff (!rst_b)
    secure && !debug_control_reg[`DTRIG_CTL_EN_BIT] |=>
      !debug_control_reg[`DTRIG_CTL_EN_BIT];
  endproperty
  a_secure: assert property (p_secure)
    else $error("enable set while secure");

  property p_cnt_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    run_state == DTRIG_IDLE && !run_start |=> $stable(valid_word_count);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold)
    else $error("count changed outside a run");

  property p_run_arm;
    @(posedge ref_clk) disable iff (!rst_b)
    run_start |=> debug_control_reg[`DTRIG_CTL_ARM_BIT] &&
                  run_state == DTRIG_RUN;
  endproperty
  a_run_arm: assert property (p_run_arm)
    else $error("arm write did not start a run");

  property p_disarm;
    @(posedge ref_clk) disable iff (!rst_b)
    wr_ctl && !pwdata[`DTRIG_CTL_ARM_BIT] |=> run_state == DTRIG_IDLE;
  endproperty
  a_disarm: assert property (p_disarm)
    else $error("run kept going after disarm write");

  property p_brk_end;
    @(posedge ref_clk) disable iff (!rst_b)
    debug_control_reg[`DTRIG_CTL_BRK_BIT] && run_end && !run_start |=>
      brk_req;
  endproperty
  a_brk_end: assert property (p_brk_end)
    else $error("no break request at run end");

  property p_tag_qual;
    @(posedge ref_clk) disable iff (!rst_b)
    trigger_config_reg[`DTRIG_CFG_QUAL_BIT] && !acc.exec_a |-> !a_m;
  endproperty
  a_tag_qual: assert property (p_tag_qual)
    else $error("tag match without execution");

endmodule : dtrig_core

// ===== sim/dtrig_acc_src.sv
/* Partner model: the bus-access source that feeds the comparators.
   Assumes the bench raises go for each cycle that carries an access. */
`timescale 1ns/1ps
module dtrig_acc_src
  import dtrig_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        go,
  input  wire logic [15:0] go_addr,
  input  wire logic [7:0]  go_data,
  input  wire logic        go_exec,
  output      dtrig_acc_s  acc
);
  // **************************************
  // Access lanes
  // **************************************
  // One access a cycle; idle lanes toggle so stale values never match.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= '{1'h0, 16'h5A5A, 8'hA5, 1'h0, 1'h0};
    end else if (go) begin
      acc <= '{1'h1, go_addr, go_data, go_exec, go_exec};
    end else begin
      acc <= '{1'h0, ~acc.addr, ~acc.data, 1'h0, 1'h0};
    end
  end
endmodule : dtrig_acc_src

// ===== sim/testbench.sv
/* Self-checking bench for the debug trigger block over APB.
   Assumes the package, the core and the access source compile first. */
`timescale 1ns/1ps
`include "dtrig_map.svh"
module testbench
  import dtrig_pkg::*;
;
  // **************************************
  // Signals and instances
  // **************************************
  localparam logic [11:0] CFG = `DTRIG_OFF_TRIG_CFG;
  localparam logic [11:0] STS = `DTRIG_OFF_STATUS;
  localparam logic [11:0] CTL = `DTRIG_OFF_DEBUG_CTL;
  logic        ref_clk, rst_b, psel, penable, pwrite, secure;
  logic        pready, pslverr, fifo_store, brk_req, trig_tag, err;
  logic        go, go_exec;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] cmp_a, cmp_b, go_addr;
  logic [7:0]  go_data;
  dtrig_acc_s  acc;
  int          error_cnt, compares, stores, brks;

  dtrig_core #(.DEPTH(8)) dtrig_core_inst (.ref_clk(ref_clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .secure(secure), .cmp_a(cmp_a), .cmp_b(cmp_b),
    .acc(acc), .fifo_store(fifo_store), .brk_req(brk_req),
    .trig_tag(trig_tag));
  dtrig_acc_src dtrig_acc_src_inst (.ref_clk(ref_clk), .rst_b(rst_b),
    .go(go), .go_addr(go_addr), .go_data(go_data), .go_exec(go_exec),
    .acc(acc));

  // Clock at 125 MHz.
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  // The host keeps its own tally of stored words and break pulses.
  always @(posedge ref_clk) begin
    if (fifo_store === 1'h1) stores++;
    if (brk_req === 1'h1) brks++;
  end

  // **************************************
  // Shared tasks
  // **************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // One APB transfer, held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      error_cnt++;
      report_and_stop;
    end
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    apb(1'h0, a, 32'h0000_0000);
    check(rdata & m, exp);
  endtask : rd

  // Back-to-back accesses, then a short settle.
  task automatic send(input logic [15:0] a, input logic [7:0] d,
                      input logic ex, input int n);
    go      <= 1'h1;
    go_addr <= a;
    go_data <= d;
    go_exec <= ex;
    repeat (n) @(posedge ref_clk);
    go <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask : send

  // **************************************
  // Scenarios
  // **************************************
  task automatic t_regs;
    rd(CFG, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(STS, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(CFG, 32'h0000_00FF);
    rd(CFG, 32'hFFFF_FFFF, 32'h0000_00CF);
    wr(STS, 32'h0000_00FF);
    rd(STS, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'h0, 12'h00C, 32'h0000_0000);
    check({err, rdata[30:0]}, 32'h8000_0000);
    secure <= 1'h1;
    wr(CTL, 32'h0000_0080);
    rd(CTL, 32'h0000_0080, 32'h0000_0000);
    secure <= 1'h0;
  endtask : t_regs

  task automatic t_lock;
    wr(CFG, 32'h0000_0081);
    @(posedge ref_clk);
    check({31'h0, trig_tag}, 32'h0000_0001);
    wr(CTL, 32'h0000_00C0);
    rd(STS, 32'h0000_0020, 32'h0000_0020);
    wr(CFG, 32'h0000_0002);
    rd(CFG, 32'h0000_00FF, 32'h0000_0081);
    wr(CTL, 32'h0000_0080);
    rd(STS, 32'h0000_0020, 32'h0000_0000);
  endtask : t_lock

  task automatic row(input logic [7:0] cfg, input logic [15:0] a1,
                     input logic [15:0] a2, input logic [7:0] d,
                     input logic ex, input logic ends);
    wr(CFG, {24'h0, cfg});
    wr(CTL, 32'h0000_00C0);
    send(a1, d, ex, 1);
    send(a2, d, ex, 1);
    rd(STS, 32'h0000_0020, ends ? 32'h0 : 32'h20);
    wr(CTL, 32'h0000_0080);
  endtask : row

  task automatic t_modes;
    row(8'h00, 16'h1000, 16'h3000, 8'h00, 1'h0, 1'h1);
    row(8'h00, 16'h2055, 16'h3000, 8'h00, 1'h0, 1'h0);
    row(8'h01, 16'h2055, 16'h3000, 8'h00, 1'h0, 1'h1);
    row(8'h02, 16'h1000, 16'h2055, 8'h00, 1'h0, 1'h1);
    row(8'h02, 16'h2055, 16'h1000, 8'h00, 1'h0, 1'h0);
    row(8'h05, 16'h1000, 16'h3000, 8'h55, 1'h0, 1'h1);
    row(8'h05, 16'h1000, 16'h3000, 8'h00, 1'h0, 1'h0);
    row(8'h06, 16'h1000, 16'h3000, 8'h00, 1'h0, 1'h1);
    row(8'h06, 16'h1000, 16'h3000, 8'h55, 1'h0, 1'h0);
    row(8'h07, 16'h1800, 16'h3000, 8'h00, 1'h0, 1'h1);
    row(8'h07, 16'h0800, 16'h3000, 8'h00, 1'h0, 1'h0);
    row(8'h08, 16'h0800, 16'h1900, 8'h00, 1'h0, 1'h1);
    row(8'h08, 16'h1800, 16'h1900, 8'h00, 1'h0, 1'h0);
    row(8'h09, 16'h1000, 16'h2055, 8'h55, 1'h0, 1'h0);
    row(8'h0F, 16'h1000, 16'h2055, 8'h55, 1'h0, 1'h0);
    row(8'h80, 16'h1000, 16'h3000, 8'h00, 1'h0, 1'h0);
    row(8'h80, 16'h1000, 16'h3000, 8'h00, 1'h1, 1'h1);
  endtask : t_modes

  task automatic t_end;
    wr(CFG, 32'h0000_0000);
    wr(CTL, 32'h0000_00D0);
    brks = 0;
    rd(STS, 32'h0000_00EF, 32'h0000_0020);
    send(16'h3000, 8'h00, 1'h0, 10);
    rd(STS, 32'h0000_00EF, 32'h0000_0028);
    send(16'h1000, 8'h00, 1'h0, 1);
    rd(STS, 32'h0000_00AF, 32'h0000_0088);
    check(brks, 32'h0000_0001);
    rd(STS, 32'h0000_00AF, 32'h0000_0088);
  endtask : t_end

  task automatic t_begin;
    wr(CFG, 32'h0000_0040);
    wr(CTL, 32'h0000_00D0);
    brks = 0;
    stores = 0;
    send(16'h3000, 8'h00, 1'h0, 3);
    check(stores, 32'h0000_0000);
    send(16'h1000, 8'h00, 1'h0, 1);
    send(16'h3000, 8'h00, 1'h0, 10);
    rd(STS, 32'h0000_00AF, 32'h0000_0088);
    check(brks, 32'h0000_0001);
    check(stores, 32'h0000_0008);
  endtask : t_begin

  task automatic t_event;
    wr(CFG, 32'h0000_0003);
    wr(CTL, 32'h0000_00C0);
    stores = 0;
    send(16'h3000, 8'h00, 1'h0, 3);
    send(16'h2055, 8'h00, 1'h0, 7);
    rd(STS, 32'h0000_002F, 32'h0000_0027);
    send(16'h2055, 8'h00, 1'h0, 1);
    rd(STS, 32'h0000_002F, 32'h0000_0008);
    check(stores, 32'h0000_0008);
    wr(CFG, 32'h0000_0004);
    wr(CTL, 32'h0000_00C0);
    stores = 0;
    send(16'h2055, 8'h00, 1'h0, 2);
    send(16'h1000, 8'h00, 1'h0, 1);
    send(16'h2055, 8'h00, 1'h0, 3);
    check(stores, 32'h0000_0003);
    wr(CTL, 32'h0000_0080);
  endtask : t_event

  // **************************************
  // Main sequence
  // **************************************
  initial begin
    rst_b   <= 1'h0;
    {psel, penable, pwrite, secure, go, go_exec} <= 6'h00;
    {paddr, pwdata, go_addr, go_data} <= 68'h0;
    cmp_a   <= 16'h1000;
    cmp_b   <= 16'h2055;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(posedge ref_clk);
    t_regs;
    t_lock;
    t_modes;
    t_end;
    t_begin;
    t_event;
    report_and_stop;
  end
endmodule : testbench
